//--- lnb_pkg.sv
// Constants shared by the two ends of the LNB supply two-wire control link
// Functional notes
// - Start/stop: data edge while clock high
// - Start or stop restarts byte sequence
// - Write: address, register, data, each acked
// - Address 00010 plus two strap bits, MSB first
// - Matching address byte acked on ninth clock
// - Write register address must be zero
// - Control data MSB first, acked after
// - Status read: four bytes, each acked
// - Master: addr, reg, stop, start, addr+read
// - Status register address is zero
// - Address with read flag is acked
// - Status shifted MSB first, master acks
// - Interrupt line open-drain, active low
// - Faults pull interrupt low and latch
// - Master ack of status clears latch
// - Off and power flags never interrupt
// - Master polls every slave on interrupt; the host does not poll, it only shows the line in FLG_IRQ
// - Port works only above port threshold
// - Current limit past 45 ms trips output
// - Thermal fault trips output until read
// - Control register zero after reset
// - Control byte field layout
// - Status byte field layout
package lnb_pkg;
  localparam int unsigned CLK_NS       = 8;
  localparam logic [4:0]  ADDR_HI      = 5'h02;
  localparam logic [7:0]  REG_ADDR     = 8'h00;
  localparam logic [7:0]  CTRL_RESET   = 8'h00;
  localparam logic [3:0]  BIT_ACK      = 4'h8;
  localparam logic [3:0]  BIT_END      = 4'h9;
  localparam int unsigned ANA_W        = 8;
  // Control byte fields
  localparam int unsigned CTL_VOLT_LO  = 0;
  localparam int unsigned CTL_VOLT_HI  = 3;
  localparam int unsigned CTL_ON       = 4;
  localparam int unsigned CTL_TONE     = 5;
  localparam int unsigned CTL_BUMP     = 6;
  localparam int unsigned CTL_SINK     = 7;
  // Status byte fields
  localparam int unsigned STS_OFF      = 0;
  localparam int unsigned STS_CP       = 1;
  localparam int unsigned STS_OC       = 2;
  localparam int unsigned STS_PNG      = 4;
  localparam int unsigned STS_TSD      = 6;
  localparam int unsigned STS_UV       = 7;
  // Overcurrent trip time
  localparam int unsigned OC_TRIP_MS   = 45;
  localparam int unsigned OC_TRIP_CYCLES = OC_TRIP_MS * 1000000 / CLK_NS;
  localparam int unsigned OC_CNT_W     = 23;
  // Host serial clock quarter period
  localparam int unsigned SCL_QUARTER_NS = 1250;
  localparam int unsigned SCL_QUARTER_CYCLES =
    (SCL_QUARTER_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned QCNT_W       = 8;
  // Host command registers
  localparam logic [2:0]  HREG_WRITE   = 3'h0;
  localparam logic [2:0]  HREG_READ    = 3'h1;
  localparam logic [2:0]  HREG_FLAGS   = 3'h2;
  localparam logic [2:0]  HREG_STATUS  = 3'h3;
  localparam int unsigned FLG_BUSY     = 0;
  localparam int unsigned FLG_NAK      = 1;
  localparam int unsigned FLG_IRQ      = 2;
  localparam int unsigned FLG_SEL_LO   = 4;
endpackage

//--- lnb_link_if.sv
// Two-wire link and interrupt line between controller and supply device
`timescale 1ns/100ps
interface lnb_link_if;
  logic scl_o;
  logic scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic irq_n_o;
  logic irq_n_oe;
  logic scl_i;
  logic sda_i;
  logic irq_n_i;

  // Pulled-up open-drain wires
  assign scl_i   = !(scl_oe && !scl_o);
  assign sda_i   = !((host_sda_oe && !host_sda_o) ||
                     (dev_sda_oe && !dev_sda_o));
  assign irq_n_i = !(irq_n_oe && !irq_n_o);

  modport host (
    output scl_o, scl_oe, host_sda_o, host_sda_oe,
    input  scl_i, sda_i, irq_n_i
  );
  modport dev (
    output dev_sda_o, dev_sda_oe, irq_n_o, irq_n_oe,
    input  scl_i, sda_i
  );
endinterface

//--- lnb_dev.sv
// Supply device end: serial slave, control register and fault latches
//
// Local design decision: strobed register access.
`timescale 1ns/100ps
module lnb_dev
  import lnb_pkg::*;
#(
  parameter int unsigned OC_CYCLES = lnb_pkg::OC_TRIP_CYCLES
) (
  input  wire logic       clk_sys,             // System clock
  input  wire logic       reset,               // Sync reset, high
  lnb_link_if.dev         link,                // Serial link pins
  input  wire logic [1:0] addr_strap,          // Low address bits
  input  wire logic       port_power_ok,       // Supply above port level
  input  wire logic       undervoltage_lockout,// Input undervoltage
  input  wire logic       current_limit_in,    // Output in current limit
  input  wire logic       overtemp_in,         // Junction overtemperature
  input  wire logic       charge_pump_good_in, // Charge pump ok
  input  wire logic       power_not_good_in,   // Output out of range
  output logic [3:0]      voltage_code,        // Output voltage code
  output logic            output_on,           // Output actually on
  output logic            tone_source_select,  // Tone source
  output logic            current_limit_bump,  // Limit boost
  output logic            internal_sink_off,   // Sink disable
  output logic [7:0]      fault_status         // Status byte image
);
  typedef enum logic [5:0] {
    S_IDLE   = 6'b000001,
    S_DEVADR = 6'b000010,
    S_REGADR = 6'b000100,
    S_WDATA  = 6'b001000,
    S_RDATA  = 6'b010000,
    S_SKIP   = 6'b100000
  } dev_state_t;

  logic [ANA_W-1:0]    in_m_q;
  logic [ANA_W-1:0]    in_s_q;
  logic                scl_p_q;
  logic                sda_p_q;
  dev_state_t          st_q;
  dev_state_t          st_d;
  logic [3:0]          cnt_q;
  logic [3:0]          cnt_d;
  logic [7:0]          sh_q;
  logic [7:0]          sh_d;
  logic [7:0]          tx_q;
  logic [7:0]          tx_d;
  logic                ack_q;
  logic                ack_d;
  logic                txon_q;
  logic                txon_d;
  logic                wr_ctrl;
  logic                rd_acked;
  logic [7:0]          ctrl_q;
  logic [2:0]          lat_q;
  logic [2:0]          lat_d;
  logic [2:0]          prev_q;
  logic                irq_q;
  logic                irq_d;
  logic [OC_CNT_W-1:0] oc_cnt_q;
  logic [7:0]          status;

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection
  wire [ANA_W-1:0] in_raw = {link.scl_i, link.sda_i, port_power_ok,
                             undervoltage_lockout, current_limit_in,
                             overtemp_in, charge_pump_good_in,
                             power_not_good_in};
  // Idle pin levels, faults inactive
  localparam logic [ANA_W-1:0] SYNC_IDLE = 8'hE2;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      in_m_q  <= SYNC_IDLE;
      in_s_q  <= SYNC_IDLE;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      in_m_q  <= in_raw;
      in_s_q  <= in_m_q;
      scl_p_q <= in_s_q[7];
      sda_p_q <= in_s_q[6];
    end
  end
  wire scl_s   = in_s_q[7];
  wire sda_s   = in_s_q[6];
  wire port_on = in_s_q[5];
  wire uv_s    = in_s_q[4];
  wire lim_s   = in_s_q[3];
  wire ot_s    = in_s_q[2];
  wire cp_s    = in_s_q[1];
  wire png_s   = in_s_q[0];
  wire rise_c  = scl_s & ~scl_p_q;
  wire fall_c  = ~scl_s & scl_p_q;
  wire start_c = scl_s & scl_p_q & sda_p_q & ~sda_s;
  wire stop_c  = scl_s & scl_p_q & ~sda_p_q & sda_s;

  //////////////////////////////////////////////////////////////////////////
  // Byte decode
  // address compare
  wire addr_ok  = sh_q[7:1] == {ADDR_HI, addr_strap};
  wire is_read  = sh_q[0];
  wire reg_ok   = sh_q == REG_ADDR;
  wire match_c  = (st_q == S_DEVADR) ? addr_ok :
                  (st_q == S_REGADR) ? reg_ok  : 1'b1;
  wire in_xfer  = (st_q != S_IDLE) && (st_q != S_SKIP);

  //////////////////////////////////////////////////////////////////////////
  // Serial sequencer
  always_comb begin
    st_d     = st_q;
    cnt_d    = cnt_q;
    sh_d     = sh_q;
    tx_d     = tx_q;
    ack_d    = ack_q;
    txon_d   = txon_q;
    wr_ctrl  = 1'b0;
    rd_acked = 1'b0;
    if (!port_on) begin
      st_d   = S_IDLE;
      ack_d  = 1'b0;
      txon_d = 1'b0;
    end else if (start_c || stop_c) begin
      st_d   = start_c ? S_DEVADR : S_IDLE;
      cnt_d  = 4'h0;
      ack_d  = 1'b0;
      txon_d = 1'b0;
    end else if (in_xfer && rise_c) begin
      cnt_d = cnt_q + 4'h1;
      if (cnt_q < BIT_ACK) begin
        sh_d = {sh_q[6:0], sda_s};
      end
      if (cnt_q == BIT_ACK && st_q == S_RDATA) begin
        rd_acked = ~sda_s;
        st_d     = S_SKIP;
      end
    end else if (in_xfer && fall_c) begin
      if (cnt_q == BIT_ACK && st_q != S_RDATA) begin
        ack_d = match_c;
        if (!match_c) begin
          st_d = S_SKIP;
        end
      end
      if (cnt_q == BIT_ACK && st_q == S_RDATA) begin
        txon_d = 1'b0;
      end
      if (st_q == S_RDATA && cnt_q != 4'h0 && cnt_q < BIT_ACK) begin
        tx_d = {tx_q[6:0], 1'b0};
      end
      if (cnt_q == BIT_END) begin
        ack_d = 1'b0;
        cnt_d = 4'h0;
        unique case (st_q)
          S_DEVADR: begin
            st_d   = is_read ? S_RDATA : S_REGADR;
            txon_d = is_read;
            tx_d   = status;
          end
          S_REGADR: st_d = S_WDATA;
          S_WDATA: begin
            wr_ctrl = 1'b1;
            st_d    = S_SKIP;
          end
          S_RDATA: st_d = S_SKIP;
          S_IDLE:  st_d = S_IDLE;
          S_SKIP:  st_d = S_SKIP;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_q   <= S_IDLE;
      cnt_q  <= 4'h0;
      sh_q   <= 8'h00;
      tx_q   <= 8'h00;
      ack_q  <= 1'b0;
      txon_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      sh_q   <= sh_d;
      tx_q   <= tx_d;
      ack_q  <= ack_d;
      txon_q <= txon_d;
    end
  end

  assign link.dev_sda_o  = 1'b0;
  assign link.dev_sda_oe = ack_q | (txon_q & ~tx_q[7]);

  //////////////////////////////////////////////////////////////////////////
  // Control register and fault latches
  // current limit timer
  wire oc_trip = oc_cnt_q == OC_CYCLES[OC_CNT_W-1:0];
  wire [2:0] now_c = {uv_s, ot_s, oc_trip};
  assign lat_d = rd_acked ? now_c : (lat_q | now_c);
  assign irq_d = (|(now_c & ~prev_q)) ? 1'b1 :
                 rd_acked ? 1'b0 : irq_q;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctrl_q   <= CTRL_RESET;
      lat_q    <= 3'h0;
      prev_q   <= 3'h0;
      irq_q    <= 1'b0;
      oc_cnt_q <= '0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= sh_q;
      end
      lat_q    <= lat_d;
      prev_q   <= now_c;
      irq_q    <= irq_d;
      oc_cnt_q <= (!lim_s) ? '0 : oc_trip ? oc_cnt_q : oc_cnt_q + 1'b1;
    end
  end

  assign link.irq_n_o  = 1'b0;
  assign link.irq_n_oe = irq_q;

  assign voltage_code       = ctrl_q[CTL_VOLT_HI:CTL_VOLT_LO];
  assign output_on          = ctrl_q[CTL_ON] & ~(|lat_q);
  assign tone_source_select = ctrl_q[CTL_TONE];
  assign current_limit_bump = ctrl_q[CTL_BUMP];
  assign internal_sink_off  = ctrl_q[CTL_SINK];

  always_comb begin
    status          = 8'h00;
    status[STS_OFF] = ~output_on;
    status[STS_CP]  = cp_s;
    status[STS_OC]  = lat_q[0];
    status[STS_PNG] = png_s;
    status[STS_TSD] = lat_q[1];
    status[STS_UV]  = lat_q[2];
  end
  assign fault_status = status;
endmodule

//--- lnb_host.sv
// Controller end: register-driven two-wire master for the supply device
`timescale 1ns/100ps
module lnb_host
  import lnb_pkg::*;
(
  input  wire logic       clk_sys,  // System clock
  input  wire logic       reset,    // Sync reset, high
  lnb_link_if.host        link,     // Serial link pins
  input  wire logic [2:0] addr,     // Register address
  input  wire logic [7:0] wdata,    // Write data
  input  wire logic       wr,       // Write strobe
  input  wire logic       rd,       // Read strobe
  output logic [7:0]      rdata     // Read data, next cycle
);
  typedef enum logic [3:0] {
    H_IDLE  = 4'b0001,
    H_START = 4'b0010,
    H_BIT   = 4'b0100,
    H_STOP  = 4'b1000
  } host_state_t;

  host_state_t       st_q;
  host_state_t       st_d;
  logic [QCNT_W-1:0] qcnt_q;
  logic [1:0]        ph_q;
  logic [1:0]        idx_q;
  logic [1:0]        idx_d;
  logic [3:0]        bitn_q;
  logic [3:0]        bitn_d;
  logic [7:0]        sh_q;
  logic [7:0]        sh_d;
  logic [7:0]        rx_q;
  logic [7:0]        rx_d;
  logic              op_rd_q;
  logic              rest_q;
  logic              rest_d;
  logic              nak_q;
  logic              nak_d;
  logic              scl_oe_q;
  logic              scl_oe_d;
  logic              sda_oe_q;
  logic              sda_oe_d;
  logic [7:0]        data_q;
  logic [1:0]        sel_q;
  logic [1:0]        sda_m_q;
  logic [1:0]        irq_m_q;

  //////////////////////////////////////////////////////////////////////////
  // Timing and pin sampling
  wire tick = qcnt_q == QCNT_W'(SCL_QUARTER_CYCLES - 1);
  wire busy = st_q != H_IDLE;
  wire sda_s = sda_m_q[1];
  wire [7:0] addr_w = {ADDR_HI, sel_q, 1'b0};
  wire [7:0] addr_r = {ADDR_HI, sel_q, 1'b1};
  wire is_rx  = op_rd_q && idx_q == 2'd3;
  wire last_b = op_rd_q ? idx_q == 2'd3 : idx_q == 2'd2;
  wire go_wr  = wr && !busy && addr == HREG_WRITE;
  wire go_rd  = wr && !busy && addr == HREG_READ;
  wire bit_oe = (bitn_q < BIT_ACK) ? (!is_rx && !sh_q[7]) : is_rx;

  //////////////////////////////////////////////////////////////////////////
  // Bus sequencer
  always_comb begin
    st_d     = st_q;
    idx_d    = idx_q;
    bitn_d   = bitn_q;
    sh_d     = sh_q;
    rx_d     = rx_q;
    rest_d   = rest_q;
    nak_d    = nak_q;
    scl_oe_d = scl_oe_q;
    sda_oe_d = sda_oe_q;
    if (go_wr || go_rd) begin
      st_d   = H_START;
      idx_d  = 2'd0;
      sh_d   = addr_w;
      nak_d  = 1'b0;
      rest_d = 1'b0;
    end else if (tick) begin
      unique case (st_q)
        H_IDLE: begin
          scl_oe_d = 1'b0;
          sda_oe_d = 1'b0;
        end
        H_START: begin
          if (ph_q == 2'd1) sda_oe_d = 1'b1;
          if (ph_q == 2'd3) begin
            scl_oe_d = 1'b1;
            st_d     = H_BIT;
            bitn_d   = 4'h0;
          end
        end
        H_BIT: begin
          if (ph_q == 2'd0) sda_oe_d = bit_oe;
          if (ph_q == 2'd1) scl_oe_d = 1'b0;
          if (ph_q == 2'd2 && bitn_q < BIT_ACK) rx_d = {rx_q[6:0], sda_s};
          if (ph_q == 2'd2 && bitn_q == BIT_ACK && !is_rx) nak_d = sda_s;
          if (ph_q == 2'd3) begin
            scl_oe_d = 1'b1;
            bitn_d   = bitn_q + 4'h1;
            sh_d     = {sh_q[6:0], 1'b0};
            if (bitn_q == BIT_ACK) begin
              bitn_d = 4'h0;
              sh_d   = (idx_q == 2'd1) ? (op_rd_q ? addr_r : data_q) :
                       REG_ADDR;
              idx_d  = idx_q + 2'd1;
              if (nak_q || last_b || (op_rd_q && idx_q == 2'd1)) begin
                st_d   = H_STOP;
                rest_d = !nak_q && op_rd_q && idx_q == 2'd1;
              end
            end
          end
        end
        H_STOP: begin
          if (ph_q == 2'd0) sda_oe_d = 1'b1;
          if (ph_q == 2'd1) scl_oe_d = 1'b0;
          if (ph_q == 2'd2) sda_oe_d = 1'b0;
          if (ph_q == 2'd3) begin
            st_d   = rest_q ? H_START : H_IDLE;
            rest_d = 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_q     <= H_IDLE;
      qcnt_q   <= '0;
      ph_q     <= 2'd0;
      idx_q    <= 2'd0;
      bitn_q   <= 4'h0;
      sh_q     <= 8'h00;
      rx_q     <= 8'h00;
      rest_q   <= 1'b0;
      nak_q    <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      sda_m_q  <= 2'b11;
      irq_m_q  <= 2'b11;
    end else begin
      st_q     <= st_d;
      qcnt_q   <= (tick || go_wr || go_rd) ? '0 : qcnt_q + 1'b1;
      ph_q     <= (go_wr || go_rd) ? 2'd0 : tick ? ph_q + 2'd1 : ph_q;
      idx_q    <= idx_d;
      bitn_q   <= bitn_d;
      sh_q     <= sh_d;
      rx_q     <= rx_d;
      rest_q   <= rest_d;
      nak_q    <= nak_d;
      scl_oe_q <= scl_oe_d;
      sda_oe_q <= sda_oe_d;
      sda_m_q  <= {sda_m_q[0], link.sda_i};
      irq_m_q  <= {irq_m_q[0], link.irq_n_i};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Command registers
  wire [7:0] flags = {2'b00, sel_q, 1'b0, ~irq_m_q[1], nak_q, busy};
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      data_q  <= 8'h00;
      sel_q   <= 2'b00;
      op_rd_q <= 1'b0;
      rdata   <= 8'h00;
    end else begin
      if (go_wr) data_q <= wdata;
      if (go_wr || go_rd) op_rd_q <= go_rd;
      if (wr && addr == HREG_FLAGS) sel_q <= wdata[FLG_SEL_LO +: 2];
      rdata <= !rd ? 8'h00 :
               (addr == HREG_FLAGS)  ? flags :
               (addr == HREG_STATUS) ? rx_q : 8'h00;
    end
  end

  assign link.scl_o       = 1'b0;
  assign link.scl_oe      = scl_oe_q;
  assign link.host_sda_o  = 1'b0;
  assign link.host_sda_oe = sda_oe_q;
endmodule

//--- lnb_link_properties.sv
// Checker for the two-wire link and interrupt line between both ends
`timescale 1ns/100ps
module lnb_link_properties
  import lnb_pkg::*;
(
  input wire logic clk_sys,     // System clock
  input wire logic reset,       // Sync reset, high
  input wire logic scl_o,       // Host clock value
  input wire logic scl_oe,      // Host pulls clock
  input wire logic host_sda_o,  // Host data value
  input wire logic host_sda_oe, // Host pulls data
  input wire logic dev_sda_o,   // Device data value
  input wire logic dev_sda_oe,  // Device pulls data
  input wire logic irq_n_o,     // Interrupt value
  input wire logic irq_n_oe,    // Interrupt pulled
  input wire logic scl_i,       // Clock wire level
  input wire logic sda_i,       // Data wire level
  input wire logic irq_n_i      // Interrupt wire level
);
  logic       scl_q;
  logic       sda_q;
  logic       rw_q;
  logic [3:0] bit_q;
  logic [1:0] byte_q;
  logic [7:0] sh_q;
  wire        rise_w = scl_i && !scl_q;
  wire        edge_w = scl_i && scl_q && (sda_i != sda_q);

  ////////////////////////////////////////////////////////////////////////////
  // Bit and byte position since the last start or stop
  always_ff @(posedge clk_sys) begin
    scl_q <= reset || scl_i;
    sda_q <= reset || sda_i;
  end
  always_ff @(posedge clk_sys) begin
    if (reset || edge_w) begin
      bit_q  <= 4'h0;
      byte_q <= 2'h0;
    end else if (rise_w) begin
      bit_q  <= (bit_q == BIT_ACK) ? 4'h0 : bit_q + 4'h1;
      byte_q <= byte_q + {1'b0, bit_q == BIT_ACK && byte_q != 2'h3};
    end
  end
  always_ff @(posedge clk_sys) begin
    if (reset || edge_w)
      rw_q <= 1'b0;
    else if (rise_w && byte_q == 2'h0 && bit_q == 4'h7)
      rw_q <= sda_i;
    if (rise_w && bit_q != BIT_ACK)
      sh_q <= {sh_q[6:0], sda_i};
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  AST_IRQ_OPEN_DRAIN: assert property (
    irq_n_oe |-> irq_n_o == 1'b0 && !irq_n_i)
    else $error("interrupt line not pulled low");
  AST_SDA_OPEN_DRAIN: assert property (
    dev_sda_oe |-> dev_sda_o == 1'b0 && !sda_i)
    else $error("device data pull not low");
  AST_SDA_STEADY: assert property (
    scl_i && scl_q |-> $stable(dev_sda_oe))
    else $error("device moved data while clock high");
  AST_RESTART_RELEASE: assert property (
    edge_w |-> !dev_sda_oe [*4])
    else $error("device drives data at start or stop");
  AST_ADDR_MATCH: assert property (
    rise_w && byte_q == 2'h0 && bit_q == BIT_ACK && dev_sda_oe
    |-> sh_q[7:3] == ADDR_HI)
    else $error("foreign address acknowledged");
  AST_ACK_NINTH: assert property (
    rise_w && dev_sda_oe && !(rw_q && byte_q == 2'h1) |-> bit_q == BIT_ACK)
    else $error("device pulled data outside ninth clock");
  AST_REG_ZERO: assert property (
    rise_w && !rw_q && byte_q == 2'h1 && bit_q == BIT_ACK && dev_sda_oe
    |-> sh_q == REG_ADDR)
    else $error("nonzero register byte acknowledged");
  AST_MASTER_ACK: assert property (
    rise_w && rw_q && byte_q == 2'h1 && bit_q == BIT_ACK |-> !dev_sda_oe)
    else $error("device drives ack of status byte");
  AST_HOST_ACK: assert property (
    rise_w && rw_q && byte_q == 2'h1 && bit_q == BIT_ACK
    |-> host_sda_oe && host_sda_o == 1'b0)
    else $error("master did not ack status byte");
  AST_SCL_OPEN_DRAIN: assert property (
    scl_oe |-> scl_o == 1'b0 && !scl_i)
    else $error("clock line not pulled low");
  AST_IRQ_CLEAR: assert property (
    $fell(irq_n_oe) |-> scl_i && !sda_i && rw_q && byte_q == 2'h2)
    else $error("interrupt released without status ack");

  cover property (rise_w && byte_q == 2'h2 && bit_q == BIT_ACK && dev_sda_oe);
  cover property (rise_w && byte_q == 2'h0 && bit_q == BIT_ACK && !dev_sda_oe);
  cover property ($fell(irq_n_oe));
endmodule

//--- test_i2c_slave_fault_irq.sv
// Bench joining controller and supply device over the two-wire link
`timescale 1ns/100ps
module test_i2c_slave_fault_irq;
  import lnb_pkg::*;
  localparam int unsigned OC_SIM = 50;
  localparam int          LIMIT  = 90000;
  logic       clk_sys     = 1'b0;
  logic       reset       = 1'b1;
  logic [2:0] addr        = 3'h0;
  logic [7:0] wdata       = 8'h00;
  logic       wr          = 1'b0;
  logic       rd          = 1'b0;
  logic       uv          = 1'b0;
  logic       ocl         = 1'b0;
  logic       ot          = 1'b0;
  logic       cp          = 1'b1;
  logic       power_not_good_flag         = 1'b0;
  logic       pok         = 1'b1;
  logic [7:0] rdata;
  logic [3:0] vcode;
  logic       on_w;
  logic       tone;
  logic       bump;
  logic       sink;
  logic [7:0] fstat;
  wire  [7:0] ctrl_w      = {sink, bump, tone, on_w, vcode};
  int         fail_count  = 0;
  int         checks_done = 0;
  int         cycles      = 0;

  always #(CLK_NS / 2) clk_sys = ~clk_sys;

  lnb_link_if lnb_link_if_i ();
  lnb_host lnb_host_i (
    .clk_sys (clk_sys),
    .reset   (reset),
    .link    (lnb_link_if_i),
    .addr    (addr),
    .wdata   (wdata),
    .wr      (wr),
    .rd      (rd),
    .rdata   (rdata)
  );
  lnb_dev #(.OC_CYCLES(OC_SIM)) lnb_dev_i (
    .clk_sys              (clk_sys),
    .reset                (reset),
    .link                 (lnb_link_if_i),
    .addr_strap           (2'h2),
    .port_power_ok        (pok),
    .undervoltage_lockout (uv),
    .current_limit_in     (ocl),
    .overtemp_in          (ot),
    .charge_pump_good_in  (cp),
    .power_not_good_in    (power_not_good_flag),
    .voltage_code         (vcode),
    .output_on            (on_w),
    .tone_source_select   (tone),
    .current_limit_bump   (bump),
    .internal_sink_off    (sink),
    .fault_status         (fstat)
  );
  lnb_link_properties lnb_link_properties_i (
    .clk_sys     (clk_sys),
    .reset       (reset),
    .scl_o       (lnb_link_if_i.scl_o),
    .scl_oe      (lnb_link_if_i.scl_oe),
    .host_sda_o  (lnb_link_if_i.host_sda_o),
    .host_sda_oe (lnb_link_if_i.host_sda_oe),
    .dev_sda_o   (lnb_link_if_i.dev_sda_o),
    .dev_sda_oe  (lnb_link_if_i.dev_sda_oe),
    .irq_n_o     (lnb_link_if_i.irq_n_o),
    .irq_n_oe    (lnb_link_if_i.irq_n_oe),
    .scl_i       (lnb_link_if_i.scl_i),
    .sda_i       (lnb_link_if_i.sda_i),
    .irq_n_i     (lnb_link_if_i.irq_n_i)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    if (fail_count == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys);
    wr    <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic wait_idle(output logic [7:0] f);
    f = 8'h01;
    for (int n = 0; n < 20000 && f[FLG_BUSY] !== 1'b0; n++)
      reg_rd(HREG_FLAGS, f);
  endtask
  task automatic set_faults(input logic [2:0] f);
    @(posedge clk_sys);
    {uv, ocl, ot} <= f;
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == LIMIT) begin
      fail_count++;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] v;
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
    check8(ctrl_w, CTRL_RESET);
    check8(fstat, 8'h03);
    reg_wr(HREG_FLAGS, 8'h20);
    reg_wr(HREG_WRITE, 8'h5A);
    wait_idle(v);
    check8(v, 8'h20);
    check8(ctrl_w, 8'h5A);
    reg_wr(HREG_FLAGS, 8'h10);
    reg_wr(HREG_WRITE, 8'hA5);
    wait_idle(v);
    check8(v, 8'h12);
    check8(ctrl_w, 8'h5A);
    reg_wr(HREG_FLAGS, 8'h20);
    // Port held below its threshold
    @(posedge clk_sys);
    pok <= 1'b0;
    reg_wr(HREG_WRITE, 8'h00);
    wait_idle(v);
    check8(v, 8'h22);
    check8(ctrl_w, 8'h5A);
    @(posedge clk_sys);
    pok <= 1'b1;
    power_not_good_flag <= 1'b1;
    cp  <= 1'b0;
    // Current limit shorter than the trip count
    set_faults(3'h2);
    repeat (20) @(posedge clk_sys);
    set_faults(3'h0);
    repeat (10) @(posedge clk_sys);
    reg_rd(HREG_FLAGS, v);
    check8(v, 8'h22);
    check8(fstat, 8'h10);
    set_faults(3'h7);
    repeat (100) @(posedge clk_sys);
    reg_rd(HREG_FLAGS, v);
    check8(v, 8'h26);
    check8(fstat, 8'hD5);
    @(posedge clk_sys);
    power_not_good_flag <= 1'b0;
    cp  <= 1'b1;
    set_faults(3'h0);
    repeat (10) @(posedge clk_sys);
    reg_rd(HREG_FLAGS, v);
    check8(v, 8'h26);
    check8(fstat, 8'hC7);
    check8({7'h0, on_w}, 8'h00);
    // Poll the other strap address first
    reg_wr(HREG_FLAGS, 8'h10);
    reg_wr(HREG_READ, 8'h00);
    wait_idle(v);
    check8(v, 8'h16);
    check8(fstat, 8'hC7);
    reg_wr(HREG_FLAGS, 8'h20);
    reg_wr(HREG_READ, 8'h00);
    wait_idle(v);
    check8(v, 8'h20);
    reg_rd(HREG_STATUS, v);
    check8(v, 8'hC7);
    check8(fstat, 8'h02);
    report_and_stop();
  end
endmodule
